// ===== hdl/pwm_pkg.sv
// Shared constants and carrier types for the two-channel pulse-width modulator.
package pwm_pkg;
    localparam int CNT_W = 16;
    localparam int PRE_W = 12;
    localparam int SRC_CLK_MHZ = 24;
    localparam int PRE_MAX = 4096;
    localparam int NUM_CH = 2;
    localparam logic [CNT_W-1:0] CNT_START = 16'h0000;
    localparam logic [PRE_W-1:0] PRE_START = 12'h000;

    typedef enum logic {
        MODE_CYCLE,
        MODE_PULSE
    } pwm_mode_e;

    // Per-channel settings; prescale holds divide factor minus one.
    typedef struct packed {
        logic enable;
        pwm_mode_e mode;
        logic active_high;
        logic [PRE_W-1:0] prescale;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] active_cycles;
    } ch_cfg_s;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [PRE_W-1:0] div;
        logic active;
        logic done;
        logic was_enabled;
        logic out;
    } ch_state_s;
endpackage

// ===== hdl/pwm_channel.sv
// One channel's prescaler: a tick once every prescale plus one clocks.
`timescale 1ns/100ps
`default_nettype none
module pwm_channel
    import pwm_pkg::*;
#(
    parameter int DIV_W = PRE_W
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic [DIV_W-1:0] prescale,
    output logic tick
);
    typedef struct packed {
        logic [DIV_W-1:0] div;
    } div_state_s;

    div_state_s s_q;
    div_state_s s_d;

    // The tick comes straight from the compare so the period counter sees it in the same cycle.
    assign tick = (s_q.div == prescale);

    always_comb begin
        s_d = s_q;
        if (clear || tick) begin
            s_d.div = '0;
        end else begin
            s_d.div = s_q.div + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/pwm_top.sv
// Top of the two-channel pulse-width modulator with pin-level settings.
//
// Functional notes
// - each channel owns a 16-bit up-counter.
// - counter resets when it reaches period.
// - period start: output active, count from zero.
// - counting clock divided by 1 to 4096.
// - cycle mode gives continuous periodic waveform.
// - pulse mode gives one positive/negative pulse.
// - two independent channels, each own output.
`timescale 1ns/100ps
`default_nettype none
module pwm_top
    import pwm_pkg::*;
#(
    parameter int CHANNELS = NUM_CH
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire ch_cfg_s cfg_zero,
    input wire ch_cfg_s cfg_one,
    input wire logic trigger_zero,
    input wire logic trigger_one,
    output logic channel_zero_output,
    output logic channel_one_output,
    output logic done_zero,
    output logic done_one
);
    // Each lane is the counting and shaping state of one channel. The prescaler of
    // each channel sits in its own small divider, so the channels never share a tick.
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic active;
        logic done;
        logic was_enabled;
        logic out;
    } lane_s;

    typedef struct packed {
        lane_s [CHANNELS-1:0] lane;
    } top_state_s;

    top_state_s s_q;
    top_state_s s_d;
    ch_cfg_s cfgs [CHANNELS];
    logic [CHANNELS-1:0] trigs;
    logic [CHANNELS-1:0] ticks;
    logic [CHANNELS-1:0] starts;
    logic [CHANNELS-1:0] clears;

    // The core clock is taken to be the 24 MHz source; a trigger is a one-cycle
    // pulse from logic on this clock, so it is not synchronised.
    assign cfgs[0] = cfg_zero;
    assign cfgs[1] = cfg_one;
    assign trigs = {trigger_one, trigger_zero};

    // Polarity picks positive-going or negative-going pulses; a disabled
    // channel rests at its inactive level.
    function automatic logic shape(ch_cfg_s c, logic active);
        logic level;
        if (c.enable) begin
            level = active ~^ c.active_high;
        end else begin
            level = ~c.active_high;
        end
        return level;
    endfunction

    // A period starts when a cycle-mode channel is first enabled, or when a
    // pulse-mode channel sees its trigger; a retrigger restarts the pulse.
    function automatic logic period_start(ch_cfg_s c, logic was_enabled, logic trig);
        logic first_cycle;
        logic pulse_go;
        first_cycle = !was_enabled && c.mode == MODE_CYCLE;
        pulse_go = c.mode == MODE_PULSE && trig;
        return c.enable && (first_cycle || pulse_go);
    endfunction

    function automatic lane_s next_lane(lane_s q, ch_cfg_s c, logic go, logic tick);
        lane_s d;
        logic running;
        logic period_end;
        logic [CNT_W-1:0] next_count;
        d = q;
        // Pulse mode counts from its trigger until the period closes, also after the
        // output has gone inactive; a zero count with the output inactive is idle.
        running = q.active || q.count != CNT_START || c.mode == MODE_CYCLE;
        period_end = q.count >= c.period;
        next_count = q.count + 1'b1;
        d.was_enabled = c.enable;
        if (!c.enable) begin
            d.count = CNT_START;
            d.active = 1'b0;
            d.done = 1'b0;
        end else if (go) begin
            d.count = CNT_START;
            d.active = 1'b1;
            d.done = 1'b0;
        end else if (tick && running) begin
            if (period_end) begin
                d.count = CNT_START;
                if (c.mode == MODE_CYCLE) begin
                    d.active = 1'b1;
                end else begin
                    d.active = 1'b0;
                    d.done = 1'b1;
                end
            end else begin
                d.count = next_count;
                if (next_count >= c.active_cycles) begin
                    d.active = 1'b0;
                end
            end
        end
        d.out = shape(c, d.active);
        return d;
    endfunction

    always_comb begin
        starts = '0;
        clears = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            starts[i] = period_start(cfgs[i], s_q.lane[i].was_enabled, trigs[i]);
            clears[i] = !cfgs[i].enable || starts[i];
        end
    end

    for (genvar i = 0; i < CHANNELS; i++) begin : g_div
        pwm_channel #(
            .DIV_W(PRE_W)
        ) u_div (
            .ref_clk(ref_clk),
            .rst(rst),
            .clear(clears[i]),
            .prescale(cfgs[i].prescale),
            .tick(ticks[i])
        );
    end

    always_comb begin
        s_d = s_q;
        for (int i = 0; i < CHANNELS; i++) begin
            s_d.lane[i] = next_lane(s_q.lane[i], cfgs[i], starts[i], ticks[i]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign channel_zero_output = s_q.lane[0].out;
    assign channel_one_output = s_q.lane[1].out;
    assign done_zero = s_q.lane[0].done;
    assign done_one = s_q.lane[1].done;
endmodule
`default_nettype wire

// ===== bench/pwm_top_assertions.sv
// Timing checker for the two-channel modulator ports.
`timescale 1ns/100ps
`default_nettype none
module pwm_top_assertions
    import pwm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire ch_cfg_s cfg_zero,
    input wire ch_cfg_s cfg_one,
    input wire logic trigger_zero,
    input wire logic trigger_one,
    input wire logic channel_zero_output,
    input wire logic channel_one_output,
    input wire logic done_zero,
    input wire logic done_one
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Cycles since channel zero last went active; a zero duty still shows one tick.
    logic act, a_q;
    logic [31:0] c_q, tick, duty;
    assign act = channel_zero_output == cfg_zero.active_high;
    assign tick = 32'(cfg_zero.prescale) + 32'h1;
    assign duty = (cfg_zero.active_cycles == 16'h0 ? 32'h1 : 32'(cfg_zero.active_cycles)) * tick;
    always_ff @(posedge ref_clk) begin
        a_q <= rst | act;
        c_q <= (act & !a_q) ? 32'h1 : c_q + 32'h1;
    end
    sequence run0;
        cfg_zero.enable && cfg_zero.mode == MODE_CYCLE && cfg_zero.active_cycles <= cfg_zero.period;
    endsequence
    a_idle_zero: assert property (!cfg_zero.enable [*2] |-> channel_zero_output != cfg_zero.active_high)
        else $error("idle zero");
    a_idle_one: assert property (!cfg_one.enable [*2] |-> channel_one_output != cfg_one.active_high)
        else $error("idle one");
    a_start_zero: assert property ($rose(cfg_zero.enable) && cfg_zero.mode == MODE_CYCLE |=> act)
        else $error("start zero");
    a_start_one: assert property ($rose(cfg_one.enable) && cfg_one.mode == MODE_CYCLE
        |=> channel_one_output == cfg_one.active_high)
        else $error("start one");
    a_pulse_one: assert property (trigger_one && cfg_one.enable && cfg_one.mode == MODE_PULSE
        |=> channel_one_output == cfg_one.active_high && !done_one)
        else $error("pulse one");
    a_cycle_done: assert property (!cfg_zero.enable ##1 run0 [*2] |-> !done_zero)
        else $error("done in cycle");
    a_duty_len: assert property (run0 ##0 (!act && a_q) |-> c_q == duty)
        else $error("duty");
    a_period_len: assert property (run0 ##0 (act && !a_q && $past(cfg_zero.enable, 2))
        |-> c_q == (32'(cfg_zero.period) + 32'h1) * tick)
        else $error("period");
endmodule
bind pwm_top pwm_top_assertions i_chk (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfg_zero(cfg_zero),
    .cfg_one(cfg_one),
    .trigger_zero(trigger_zero),
    .trigger_one(trigger_one),
    .channel_zero_output(channel_zero_output),
    .channel_one_output(channel_one_output),
    .done_zero(done_zero),
    .done_one(done_one)
);
`default_nettype wire

// ===== bench/two_channel_pwm_generator_test.sv
// Self-checking bench for the two-channel modulator.
`timescale 1ns/100ps
`default_nettype none
module two_channel_pwm_generator_test import pwm_pkg::*; ;
    logic ref_clk = 0, rst = 1, trigger_zero = 0, trigger_one = 0;
    logic channel_zero_output, channel_one_output, done_zero, done_one;
    ch_cfg_s cfg_zero = {3'h1, 44'h0}, cfg_one = {3'h1, 44'h0};
    int err_count = 0, n_compared = 0;
    pwm_top i_dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .cfg_zero(cfg_zero),
        .cfg_one(cfg_one),
        .trigger_zero(trigger_zero),
        .trigger_one(trigger_one),
        .channel_zero_output(channel_zero_output),
        .channel_one_output(channel_one_output),
        .done_zero(done_zero),
        .done_one(done_one)
    );
    always #50 ref_clk = ~ref_clk;
    task chk(logic v, logic e);
        n_compared++;
        if (v !== e) begin
            err_count++;
            $display("[ERR] %0t output mismatch", $time);
        end
    endtask
    function automatic logic ex(ch_cfg_s c, int k);
        int t = c.prescale + 1;
        int p = (c.period + 1) * t;
        if (!c.enable || (c.mode == MODE_PULSE && k >= p)) return !c.active_high;
        return (k % p < c.active_cycles * t) ? c.active_high : !c.active_high;
    endfunction
    task run(int n, int k0 = 0);
        for (int k = k0; k < k0 + n; k++) begin
            @(negedge ref_clk);
            trigger_zero = 0;
            trigger_one = 0;
            chk(channel_zero_output, ex(cfg_zero, k));
            chk(channel_one_output, ex(cfg_one, k));
        end
    endtask
    task t_cycle;
        @(negedge ref_clk);
        cfg_zero = '{1'b1, MODE_CYCLE, 1'b1, 12'h001, 16'h0004, 16'h0002};
        cfg_one = '{1'b1, MODE_CYCLE, 1'b0, 12'h000, 16'h0002, 16'h0001};
        run(15);
        // Triggers in cycle mode are ignored, so the waveform runs on unchanged.
        trigger_zero = 1;
        trigger_one = 1;
        run(15, 15);
        cfg_zero.enable = 0;
        cfg_one.enable = 0;
        run(2);
    endtask
    task t_pulse;
        cfg_zero = '{1'b1, MODE_PULSE, 1'b1, 12'h002, 16'h0003, 16'h0002};
        cfg_one = '{1'b1, MODE_PULSE, 1'b0, 12'h000, 16'h0001, 16'h0001};
        @(negedge ref_clk);
        trigger_zero = 1;
        trigger_one = 1;
        run(20);
        chk(done_zero, 1'b1);
        chk(done_one, 1'b1);
    endtask
    task results;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        rst = 0;
        t_cycle;
        t_pulse;
        results;
    end
    // Tests need well under a hundred cycles; this allows forty times that.
    initial begin
        #400000;
        err_count++;
        results;
    end
endmodule
`default_nettype wire
